// [qie_map.svh]
// Offsets, field positions, status codes and timing counts of the queue engine.
`ifndef QIE_MAP_SVH
`define QIE_MAP_SVH

// ==================================================================
// Link offsets inside a queue entry
`define QIE_FWD_OFS        64'h0000000000000000
`define QIE_LW_BACK_OFS    64'h0000000000000004
`define QIE_QW_BACK_OFS    64'h0000000000000008

// ==================================================================
// Field positions
`define QIE_LOCK_BIT       0
`define QIE_LW_ALIGN_MSB   2
`define QIE_QW_ALIGN_MSB   3

// ==================================================================
// Status values returned in result_register
`define QIE_R0_NOT_EMPTY   64'h0000000000000000
`define QIE_R0_WAS_EMPTY   64'h0000000000000001
`define QIE_R0_REM_EMPTY   64'h0000000000000000
`define QIE_R0_REM_MORE    64'h0000000000000001
`define QIE_R0_REM_NOW     64'h0000000000000002
`define QIE_R0_LOCK_FAIL   64'hffffffffffffffff

// ==================================================================
// Timing counts
`define QIE_RETRY_DEFAULT  16'h0010

`endif

// [qie_pkg.sv]
// Types shared by the queue insert and remove engine.
`default_nettype none
package qie_pkg;

	// ==================================================================
	// Operations the processor may issue
	typedef enum logic [2:0] {
		QIE_INSERT_LONG_QUEUE          = 3'h0,
		QIE_INSERT_LONG_QUEUE_DEFERRED = 3'h1,
		QIE_INSERT_QUAD_QUEUE          = 3'h2,
		QIE_INSERT_QUAD_QUEUE_DEFERRED = 3'h3,
		QIE_REMOVE_LONG_HEAD_LOCKED    = 3'h4
	} qie_cmd_t;

	// ==================================================================
	// Memory side operations
	typedef enum logic [2:0] {
		QIE_MEM_READ              = 3'h0,
		QIE_MEM_WRITE             = 3'h1,
		QIE_MEM_PROBE_WRITE       = 3'h2,
		QIE_MEM_LOCKED_LOAD       = 3'h3,
		QIE_MEM_CONDITIONAL_STORE = 3'h4,
		QIE_MEM_MEMORY_BARRIER    = 3'h5
	} qie_mop_t;

	// ==================================================================
	// Exception classes
	typedef enum logic [2:0] {
		QIE_EXC_NONE                  = 3'h0,
		QIE_EXC_ACCESS_VIOLATION      = 3'h1,
		QIE_EXC_FAULT_ON_READ         = 3'h2,
		QIE_EXC_FAULT_ON_WRITE        = 3'h3,
		QIE_EXC_TRANSLATION_NOT_VALID = 3'h4,
		QIE_EXC_ILLEGAL_OPERAND       = 3'h5
	} qie_exc_t;

	// ==================================================================
	// Sequencer states, one-hot
	typedef enum logic [12:0] {
		QIE_ST_IDLE      = 13'h0001,
		QIE_ST_CHECK     = 13'h0002,
		QIE_ST_DEFER_RD  = 13'h0004,
		QIE_ST_FWD_RD    = 13'h0008,
		QIE_ST_INS_PROBE = 13'h0010,
		QIE_ST_INS_WRITE = 13'h0020,
		QIE_ST_LOCK_LD   = 13'h0040,
		QIE_ST_LOCK_SC   = 13'h0080,
		QIE_ST_LOCK_MB   = 13'h0100,
		QIE_ST_ENTRY_RD  = 13'h0200,
		QIE_ST_REM_PROBE = 13'h0400,
		QIE_ST_REM_WRITE = 13'h0800,
		QIE_ST_RESTORE   = 13'h1000
	} qie_state_t;

	// ==================================================================
	// Whole state of the engine
	typedef struct packed {
		qie_state_t  state;
		qie_cmd_t    cmd;
		logic [63:0] hdr;
		logic [63:0] ent;
		logic [63:0] pred;
		logic [63:0] link;
		logic [63:0] lockv;
		logic [63:0] succ;
		logic [1:0]  step;
		logic [15:0] retry;
		qie_exc_t    pend_exc;
		logic        busy;
		logic        done;
		logic [63:0] result0;
		logic [63:0] result1;
		qie_exc_t    exc;
		logic        mem_req;
		qie_mop_t    mem_op;
		logic [63:0] mem_addr;
		logic        mem_quad;
		logic [63:0] mem_wdata;
	} qie_st_t;

	// Sign extension of a longword to a full address.
	function automatic logic [63:0] qie_sext32(input logic [63:0] v);
		return {{32{v[31]}}, v[31:0]};
	endfunction

endpackage
`default_nettype wire

// [qie_chk.sv]
// Operand alignment and address form checks for the queue engine.
`timescale 1ns/1ps
`default_nettype none
`include "qie_map.svh"

module qie_chk (
	// Operands
	input  wire logic [63:0] hdr,
	input  wire logic [63:0] ent,
	input  wire logic [63:0] rdata,
	// Results
	output logic      [63:0] rd_sext,
	output logic             hdr_quad_bad,
	output logic             ent_quad_bad,
	output logic             rd_quad_bad,
	output logic             hdr_rem_bad
);
	import qie_pkg::*;

	// ==================================================================
	// Checks
	// Longword links are stored as 32 bits and widened on read.
	assign rd_sext      = qie_sext32(rdata);
	assign hdr_quad_bad = |hdr[`QIE_QW_ALIGN_MSB:0];
	assign ent_quad_bad = |ent[`QIE_QW_ALIGN_MSB:0];
	assign rd_quad_bad  = |rdata[`QIE_QW_ALIGN_MSB:0];
	// A header must be aligned and reachable as a 32 bit address.
	assign hdr_rem_bad  = (|hdr[`QIE_LW_ALIGN_MSB:0]) || (qie_sext32(hdr) != hdr);

endmodule // qie_chk
`default_nettype wire

// [qie_engine.sv]
// Queue insert and interlocked head remove engine.
// Notes on behaviour
// - Longword insert links new entry (arg two) right after predecessor (arg one).
// - Deferred longword insert reads predecessor address from longword at arg one, sign-extended.
// - Insert writes entry forward, entry backward, successor backward, predecessor forward, in order.
// - Longword inserts accept any byte alignment, no alignment exception.
// - Insert returns 1 if predecessor pointed to itself, else 0.
// - Every insert access is validated before any write; otherwise fault, queue untouched.
// - Faults classed as access violation, read fault, write fault, translation not valid.
// - Quad insert: illegal operand when predecessor or entry bits 3:0 nonzero.
// - Deferred quad insert: illegal operand if arg one bits 3:0 nonzero, else read.
// - Quad insert: predecessor forward link with bits 3:0 set is illegal operand.
// - On quad insert exceptions result is undefined; report order is free.
// - Remove: illegal operand on unaligned header or header not a 32 bit address.
// - Remove takes lock by locked load then conditional store with bit 0; else -1.
// - After lock and barrier, misaligned header link restores header, illegal operand.
// - If remove accesses cannot complete, restore header, then memory management fault.
// - Removed entry and successor computed; successor backward written, barrier, header forward.
// - Remove returns 0 was empty, 2 now empty, 1 still full; entry in result two.
// - Remove is non-interruptible and interlocked against other interlocked queue users.
`timescale 1ns/1ps
`default_nettype none
`include "qie_map.svh"

module qie_engine #(
	parameter logic [15:0] RETRY_LIMIT = `QIE_RETRY_DEFAULT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// Operation request from the processor
	input  wire logic              start,
	input  wire qie_pkg::qie_cmd_t cmd,
	input  wire logic [63:0]       first_argument_register,
	input  wire logic [63:0]       second_argument_register,
	// Operation answer
	output logic                   busy,
	output logic                   done,
	output logic [63:0]            result_register,
	output logic [63:0]            second_result_register,
	output qie_pkg::qie_exc_t      exc,
	// Memory side
	output logic                   mem_req,
	output qie_pkg::qie_mop_t      mem_op,
	output logic [63:0]            mem_addr,
	output logic                   mem_quad,
	output logic [63:0]            mem_wdata,
	input  wire logic              mem_ack,
	input  wire logic [63:0]       mem_rdata,
	input  wire logic              mem_fault,
	input  wire qie_pkg::qie_exc_t mem_fault_code,
	input  wire logic              mem_sc_ok
);
	import qie_pkg::*;

	// ==================================================================
	// State and helpers
	localparam qie_st_t ST_RESET = '{
		state: QIE_ST_IDLE, cmd: QIE_INSERT_LONG_QUEUE, pend_exc: QIE_EXC_NONE,
		exc: QIE_EXC_NONE, mem_op: QIE_MEM_READ, default: '0};

	qie_st_t     s;
	qie_st_t     next_s;
	logic [63:0] rd_sext;
	logic        hdr_quad_bad;
	logic        ent_quad_bad;
	logic        rd_quad_bad;
	logic        hdr_rem_bad;
	logic        quad;
	logic [63:0] bofs;
	logic [63:0] ins_addr;
	logic [63:0] ins_data;
	logic [63:0] rd_val;
	logic [63:0] new_succ;

	// Launches one memory access; the request stands until acknowledged.
	function automatic qie_st_t issue(input qie_st_t c, input qie_mop_t op, input logic [63:0] a,
			input logic q, input logic [63:0] d);
		qie_st_t r;
		r           = c;
		r.mem_req   = 1'b1;
		r.mem_op    = op;
		r.mem_addr  = a;
		r.mem_quad  = q;
		r.mem_wdata = d;
		return r;
	endfunction

	// Ends the operation; results are only updated when no exception is raised.
	function automatic qie_st_t finish(input qie_st_t c, input logic [63:0] r0, input qie_exc_t e);
		qie_st_t r;
		r       = c;
		r.state = QIE_ST_IDLE;
		r.busy  = 1'b0;
		r.done  = 1'b1;
		r.exc   = e;
		if (e == QIE_EXC_NONE) begin
			r.result0 = r0;
		end
		return r;
	endfunction

	qie_chk u_chk (
		.hdr          (s.hdr),
		.ent          (s.ent),
		.rdata        (mem_rdata),
		.rd_sext      (rd_sext),
		.hdr_quad_bad (hdr_quad_bad),
		.ent_quad_bad (ent_quad_bad),
		.rd_quad_bad  (rd_quad_bad),
		.hdr_rem_bad  (hdr_rem_bad)
	);

	// ==================================================================
	// Operand forms and the four insert link writes
	assign quad   = (s.cmd == QIE_INSERT_QUAD_QUEUE) || (s.cmd == QIE_INSERT_QUAD_QUEUE_DEFERRED);
	assign bofs   = quad ? `QIE_QW_BACK_OFS : `QIE_LW_BACK_OFS;
	assign rd_val = quad ? mem_rdata : rd_sext;
	// Successor of the removed entry, wrapped to 32 bits like every remove address.
	assign new_succ = qie_sext32(s.pred + rd_sext);

	// The probe pass and the write pass walk the same address list, so what was
	// validated is exactly what gets written.
	always_comb begin
		ins_addr = s.ent + `QIE_FWD_OFS;
		ins_data = s.link;
		case (s.step)
			2'h0: begin
				ins_addr = s.ent + `QIE_FWD_OFS;
				ins_data = s.link;
			end
			2'h1: begin
				ins_addr = s.ent + bofs;
				ins_data = s.pred;
			end
			2'h2: begin
				ins_addr = s.link + bofs;
				ins_data = s.ent;
			end
			default: begin
				ins_addr = s.pred + `QIE_FWD_OFS;
				ins_data = s.ent;
			end
		endcase
	end

	// ==================================================================
	// Sequencer
	// No abort input exists: once started, an operation always runs to its end.
	always_comb begin
		next_s      = s;
		next_s.done = 1'b0;
		case (s.state)
			QIE_ST_IDLE: begin
				if (start) begin
					next_s.cmd   = cmd;
					next_s.hdr   = first_argument_register;
					next_s.ent   = second_argument_register;
					next_s.pred  = first_argument_register;
					next_s.busy  = 1'b1;
					next_s.exc   = QIE_EXC_NONE;
					next_s.step  = 2'h0;
					next_s.state = QIE_ST_CHECK;
				end
			end
			QIE_ST_CHECK: begin
				// Longword inserts skip every alignment check.
				case (s.cmd)
					QIE_INSERT_LONG_QUEUE: next_s.state = QIE_ST_FWD_RD;
					QIE_INSERT_LONG_QUEUE_DEFERRED: next_s.state = QIE_ST_DEFER_RD;
					QIE_INSERT_QUAD_QUEUE: begin
						if (hdr_quad_bad || ent_quad_bad) begin
							next_s = finish(s, 64'h0, QIE_EXC_ILLEGAL_OPERAND);
						end else begin
							next_s.state = QIE_ST_FWD_RD;
						end
					end
					QIE_INSERT_QUAD_QUEUE_DEFERRED: begin
						if (hdr_quad_bad) begin
							next_s = finish(s, 64'h0, QIE_EXC_ILLEGAL_OPERAND);
						end else begin
							next_s.state = QIE_ST_DEFER_RD;
						end
					end
					default: begin
						if (hdr_rem_bad) begin
							next_s = finish(s, 64'h0, QIE_EXC_ILLEGAL_OPERAND);
						end else begin
							next_s.retry = RETRY_LIMIT;
							next_s.state = QIE_ST_LOCK_LD;
						end
					end
				endcase
			end
			QIE_ST_DEFER_RD: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_READ, s.hdr, quad, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.pred    = rd_val;
					if (mem_fault) begin
						next_s = finish(next_s, 64'h0, mem_fault_code);
					end else if (quad && (rd_quad_bad || ent_quad_bad)) begin
						next_s = finish(next_s, 64'h0, QIE_EXC_ILLEGAL_OPERAND);
					end else begin
						next_s.state = QIE_ST_FWD_RD;
					end
				end
			end
			QIE_ST_FWD_RD: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_READ, s.pred + `QIE_FWD_OFS, quad, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.link    = rd_val;
					if (mem_fault) begin
						next_s = finish(next_s, 64'h0, mem_fault_code);
					end else if (quad && rd_quad_bad) begin
						next_s = finish(next_s, 64'h0, QIE_EXC_ILLEGAL_OPERAND);
					end else begin
						next_s.step  = 2'h0;
						next_s.state = QIE_ST_INS_PROBE;
					end
				end
			end
			QIE_ST_INS_PROBE: begin
				// Every write target is probed before the first link is touched.
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_PROBE_WRITE, ins_addr, quad, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.step    = s.step + 2'h1;
					if (mem_fault) begin
						next_s = finish(next_s, 64'h0, mem_fault_code);
					end else if (s.step == 2'h3) begin
						next_s.state = QIE_ST_INS_WRITE;
					end
				end
			end
			QIE_ST_INS_WRITE: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_WRITE, ins_addr, quad, ins_data);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.step    = s.step + 2'h1;
					if (s.step == 2'h3) begin
						// A self-pointing predecessor means the queue was empty.
						next_s = finish(next_s, (s.link == s.pred) ? `QIE_R0_WAS_EMPTY
							: `QIE_R0_NOT_EMPTY, QIE_EXC_NONE);
					end
				end
			end
			QIE_ST_LOCK_LD: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_LOCKED_LOAD, s.hdr, 1'b1, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.lockv   = mem_rdata;
					if (mem_fault) begin
						next_s = finish(next_s, 64'h0, mem_fault_code);
					end else begin
						next_s.state = QIE_ST_LOCK_SC;
					end
				end
			end
			QIE_ST_LOCK_SC: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_CONDITIONAL_STORE, s.hdr, 1'b1,
						s.lockv | 64'h1);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					if (mem_fault) begin
						next_s = finish(next_s, 64'h0, mem_fault_code);
					end else if (mem_sc_ok) begin
						next_s.state = QIE_ST_LOCK_MB;
					end else if (s.retry <= 16'h1) begin
						next_s.retry = 16'h0;
						next_s = finish(next_s, `QIE_R0_LOCK_FAIL, QIE_EXC_NONE);
					end else begin
						next_s.retry = s.retry - 16'h1;
						next_s.state = QIE_ST_LOCK_LD;
					end
				end
			end
			QIE_ST_LOCK_MB: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_MEMORY_BARRIER, s.hdr, 1'b1, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.link    = qie_sext32(s.lockv);
					next_s.pred    = qie_sext32(s.hdr + qie_sext32(s.lockv));
					if (|s.lockv[`QIE_LW_ALIGN_MSB:0]) begin
						next_s.pend_exc = QIE_EXC_ILLEGAL_OPERAND;
						next_s.state    = QIE_ST_RESTORE;
					end else if (qie_sext32(s.lockv) == 64'h0) begin
						next_s.succ  = s.hdr;
						next_s.state = QIE_ST_REM_PROBE;
					end else begin
						next_s.state = QIE_ST_ENTRY_RD;
					end
				end
			end
			QIE_ST_ENTRY_RD: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_READ, s.pred, 1'b0, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.succ    = new_succ;
					if (mem_fault) begin
						next_s.pend_exc = mem_fault_code;
						next_s.state    = QIE_ST_RESTORE;
					end else if (|new_succ[`QIE_LW_ALIGN_MSB:0]) begin
						next_s.pend_exc = QIE_EXC_ILLEGAL_OPERAND;
						next_s.state    = QIE_ST_RESTORE;
					end else begin
						next_s.state = QIE_ST_REM_PROBE;
					end
				end
			end
			QIE_ST_REM_PROBE: begin
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_PROBE_WRITE, s.succ + `QIE_LW_BACK_OFS, 1'b0, 64'h0);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.step    = 2'h0;
					if (mem_fault) begin
						next_s.pend_exc = mem_fault_code;
						next_s.state    = QIE_ST_RESTORE;
					end else begin
						next_s.state = QIE_ST_REM_WRITE;
					end
				end
			end
			QIE_ST_REM_WRITE: begin
				// Step 0 successor backward link, step 1 barrier, step 2 header link.
				if (!s.mem_req) begin
					if (s.step == 2'h0) begin
						next_s = issue(s, QIE_MEM_WRITE, s.succ + `QIE_LW_BACK_OFS, 1'b0,
							s.hdr - s.succ);
					end else if (s.step == 2'h1) begin
						next_s = issue(s, QIE_MEM_MEMORY_BARRIER, s.hdr, 1'b0, 64'h0);
					end else begin
						// Writing the header clears the lock bit and releases the queue.
						next_s = issue(s, QIE_MEM_WRITE, s.hdr, 1'b0, s.succ - s.hdr);
					end
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s.step    = s.step + 2'h1;
					if (s.step == 2'h2) begin
						next_s.result1 = s.pred;
						if (s.link == 64'h0) begin
							next_s = finish(next_s, `QIE_R0_REM_EMPTY, QIE_EXC_NONE);
						end else if (s.succ == s.hdr) begin
							next_s = finish(next_s, `QIE_R0_REM_NOW, QIE_EXC_NONE);
						end else begin
							next_s = finish(next_s, `QIE_R0_REM_MORE, QIE_EXC_NONE);
						end
					end
				end
			end
			QIE_ST_RESTORE: begin
				// Put back the header as it was before the lock bit was set.
				if (!s.mem_req) begin
					next_s = issue(s, QIE_MEM_WRITE, s.hdr, 1'b0, s.lockv);
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					next_s = finish(next_s, 64'h0, s.pend_exc);
				end
			end
			default: begin
				next_s = ST_RESET;
			end
		endcase
	end

	// ==================================================================
	// State register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==================================================================
	// Outputs, straight from the state register
	assign busy                   = s.busy;
	assign done                   = s.done;
	assign result_register        = s.result0;
	assign second_result_register = s.result1;
	assign exc                    = s.exc;
	assign mem_req                = s.mem_req;
	assign mem_op                 = s.mem_op;
	assign mem_addr               = s.mem_addr;
	assign mem_quad               = s.mem_quad;
	assign mem_wdata              = s.mem_wdata;

endmodule // qie_engine
`default_nettype wire

// [qie_engine_properties.sv]
// Port-level timing and operand checks for the queue engine.
`timescale 1ns/1ps
`default_nettype none
module qie_engine_properties (
	// Processor side
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire logic              start,
	input wire qie_pkg::qie_cmd_t cmd,
	input wire logic [63:0]       first_argument_register,
	input wire logic [63:0]       second_argument_register,
	input wire logic              busy,
	input wire logic              done,
	input wire qie_pkg::qie_exc_t exc,
	// Memory side
	input wire logic              mem_req,
	input wire qie_pkg::qie_mop_t mem_op,
	input wire logic [63:0]       mem_addr,
	input wire logic [63:0]       mem_wdata,
	input wire logic              mem_ack
);
	import qie_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// An accepted request and its header operand in short form.
	wire logic        take = start && !busy;
	wire logic [63:0] a1   = first_argument_register;
	// ==================================================================
	// Assertions
	a_req_stable: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
		else $error("memory request changed before its ack");
	a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("no idle cycle after a memory ack");
	a_done_pulse: assert property (done |=> !done)
		else $error("done lasted more than one cycle");
	a_busy_end: assert property ($fell(busy) |-> done)
		else $error("busy fell without done");
	a_take_busy: assert property (take |=> busy)
		else $error("accepted request did not raise busy");
	a_quad_align: assert property (
		take && cmd == QIE_INSERT_QUAD_QUEUE && (a1[3:0] != 4'h0 || second_argument_register[3:0] != 4'h0)
		|-> ##2 done && exc == QIE_EXC_ILLEGAL_OPERAND) else $error("misaligned quad insert accepted");
	a_hdr_form: assert property (
		take && cmd == QIE_REMOVE_LONG_HEAD_LOCKED && (a1[2:0] != 3'h0 || a1[63:32] != {32{a1[31]}})
		|-> ##2 done && exc == QIE_EXC_ILLEGAL_OPERAND) else $error("bad remove header accepted");
	a_lock_bit: assert property (mem_req && mem_op == QIE_MEM_CONDITIONAL_STORE |-> mem_wdata[0])
		else $error("conditional store without lock bit");
	c_remove: cover property (take && cmd == QIE_REMOVE_LONG_HEAD_LOCKED);
	c_clean: cover property (done && exc == QIE_EXC_NONE);
	c_fault: cover property (done && exc != QIE_EXC_NONE);
endmodule // qie_engine_properties
bind qie_engine qie_engine_properties u_props (.core_clk, .resetn, .start, .cmd, .first_argument_register,
	.second_argument_register, .busy, .done, .exc, .mem_req, .mem_op, .mem_addr, .mem_wdata, .mem_ack);
`default_nettype wire

// [qie_mem_model.sv]
// Behavioural memory that answers the queue engine's accesses.
`timescale 1ns/1ps
`default_nettype none
module qie_mem_model (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// Requests
	input  wire logic              mem_req,
	input  wire qie_pkg::qie_mop_t mem_op,
	input  wire logic [63:0]       mem_addr,
	input  wire logic              mem_quad,
	input  wire logic [63:0]       mem_wdata,
	// Answers
	output logic                   mem_ack,
	output logic [63:0]            mem_rdata,
	output logic                   mem_fault,
	output qie_pkg::qie_exc_t      mem_fault_code,
	output logic                   mem_sc_ok
);
	import qie_pkg::*;
	logic [31:0] m [logic [63:0]];
	logic [63:0] flt_addr = '1;
	qie_exc_t    flt_code = QIE_EXC_NONE;
	int          sc_fails = 0;
	int          wait_n   = 0;
	logic        bad;
	// Answers after a random wait; read data toggles while no request is pending so stale values never look valid.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			mem_fault <= 1'b0;
			mem_fault_code <= QIE_EXC_NONE;
			mem_sc_ok <= 1'b0;
			mem_rdata <= '0;
		end else if (mem_ack || !mem_req) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (wait_n != 0) begin
			wait_n = wait_n - 1;
		end else begin
			bad = mem_addr == flt_addr && mem_op inside {QIE_MEM_READ, QIE_MEM_PROBE_WRITE};
			mem_ack <= 1'b1;
			mem_fault <= bad;
			mem_fault_code <= bad ? flt_code : QIE_EXC_NONE;
			mem_sc_ok <= sc_fails == 0;
			// Only reads look into the array, so probing a fresh address never hits a missing entry.
			if (mem_op inside {QIE_MEM_READ, QIE_MEM_LOCKED_LOAD})
				mem_rdata <= {mem_quad ? m[mem_addr + 4] : ~m[mem_addr], m[mem_addr]};
			if (mem_op == QIE_MEM_WRITE || (mem_op == QIE_MEM_CONDITIONAL_STORE && sc_fails == 0)) begin
				m[mem_addr] = mem_wdata[31:0];
				if (mem_quad) m[mem_addr + 4] = mem_wdata[63:32];
			end
			if (mem_op == QIE_MEM_CONDITIONAL_STORE && sc_fails != 0) sc_fails = sc_fails - 1;
			wait_n = $urandom % 3;
		end
	end
endmodule // qie_mem_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the queue insert and remove engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
	import qie_pkg::*;
	localparam logic [63:0] H = 64'h6000;
	localparam qie_exc_t ILL = QIE_EXC_ILLEGAL_OPERAND;
	logic        core_clk, resetn, start, busy, done, mem_req, mem_quad, mem_ack, mem_fault, mem_sc_ok;
	logic [63:0] a1, a2, r0, r1, mem_addr, mem_wdata, mem_rdata, p, e;
	qie_cmd_t    cmd;
	qie_exc_t    exc, mem_fault_code;
	qie_mop_t    mem_op;
	int          fail_count = 0;
	int          n_tests = 0;
	int          i;
	qie_engine #(.RETRY_LIMIT(16'h0002)) DUT (.core_clk, .resetn, .start, .cmd, .first_argument_register(a1),
		.second_argument_register(a2), .busy, .done, .result_register(r0), .second_result_register(r1), .exc,
		.mem_req, .mem_op, .mem_addr, .mem_quad, .mem_wdata, .mem_ack, .mem_rdata, .mem_fault, .mem_fault_code,
		.mem_sc_ok);
	qie_mem_model MEM (.core_clk, .resetn, .mem_req, .mem_op, .mem_addr, .mem_quad, .mem_wdata, .mem_ack,
		.mem_rdata, .mem_fault, .mem_fault_code, .mem_sc_ok);
	// Remove status from the old header link and the new successor offset.
	function automatic logic [63:0] rem_status(input logic [31:0] link, input logic [31:0] succ);
		return link == 0 ? 64'h0 : succ == 0 ? 64'h2 : 64'h1;
	endfunction
	// Prints the verdict and ends the run.
	task automatic print_verdict();
		if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Issues one operation and waits, bounded, for done.
	task automatic op(input qie_cmd_t c, input logic [63:0] x, input logic [63:0] y, input qie_exc_t ex);
		int k;
		@(posedge core_clk) #1;
		start = 1'b1;
		cmd = c;
		a1 = x;
		a2 = y;
		@(posedge core_clk) #1;
		start = 1'b0;
		for (k = 0; k < 500 && done !== 1'b1; k++) @(posedge core_clk) #1;
		`CHK("done", 1'b1, done)
		`CHK("exception", ex, exc)
	endtask
	// Builds a header and first entry, removes once, checks the header left behind.
	task automatic rem(input logic [31:0] link, efwd, input int fails, input logic [63:0] flt, input qie_exc_t ex,
		input logic [31:0] hdr);
		MEM.m[H] = link;
		MEM.m[H + 4] = 32'h0;
		MEM.m[H + 64'h100] = efwd;
		MEM.sc_fails = fails;
		MEM.flt_addr = flt;
		MEM.flt_code = QIE_EXC_FAULT_ON_READ;
		op(QIE_REMOVE_LONG_HEAD_LOCKED, H, 64'h0, ex);
		`CHK("header", hdr, MEM.m[H])
	endtask
	// ==================================================================
	// Clock, watchdog and sequence
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		#800000;
		fail_count++;
		print_verdict();
	end
	initial begin
		i = $urandom(32'hacc71c50);
		{resetn, start, a1, a2} = '0;
		cmd = QIE_INSERT_LONG_QUEUE;
		repeat (4) @(posedge core_clk);
		#1 resetn = 1'b1;
		// Byte-aligned inserts at random places, plain and deferred, into empty then busy queues.
		for (i = 0; i < 6; i++) begin
			p = 64'h1000 + i * 64'h200 + $urandom % 64;
			e = p + 64'h80 + $urandom % 64;
			MEM.m[p] = p[31:0];
			MEM.m[p + 4] = p[31:0];
			MEM.m[p + 64'h180] = p[31:0];
			op(qie_cmd_t'(i % 2), i % 2 ? p + 64'h180 : p, e, QIE_EXC_NONE);
			`CHK("empty status", 64'h1, r0)
			`CHK("entry links", {p[31:0], p[31:0], e[31:0]}, {MEM.m[e + 4], MEM.m[e], MEM.m[p + 4]})
			op(QIE_INSERT_LONG_QUEUE, p, e + 64'h40, QIE_EXC_NONE);
			`CHK("busy status", 64'h0, r0)
			`CHK("new links", {e[31:0], e[31:0] + 32'h40}, {MEM.m[e + 64'h40], MEM.m[p]})
		end
		// Every fault class on a probe leaves the predecessor unchanged.
		for (i = 1; i < 5; i++) begin
			MEM.m[p] = p[31:0];
			MEM.flt_addr = e + 4;
			MEM.flt_code = qie_exc_t'(i);
			op(QIE_INSERT_LONG_QUEUE, p, e, qie_exc_t'(i));
			`CHK("pred kept", p[31:0], MEM.m[p])
		end
		op(QIE_INSERT_QUAD_QUEUE, 64'h4008, 64'h5000, ILL);
		op(QIE_INSERT_QUAD_QUEUE, 64'h4000, 64'h5001, ILL);
		op(QIE_INSERT_QUAD_QUEUE_DEFERRED, 64'h3004, 64'h5000, ILL);
		MEM.m[64'h4000] = 32'h4002;
		MEM.m[64'h4004] = 32'h0;
		MEM.m[64'h5000] = 32'h77;
		op(QIE_INSERT_QUAD_QUEUE, 64'h4000, 64'h5000, ILL);
		`CHK("entry kept", 32'h77, MEM.m[64'h5000])
		MEM.m[64'h3000] = 32'h4000;
		MEM.m[64'h3004] = 32'h0;
		MEM.m[64'h4000] = 32'h4000;
		op(QIE_INSERT_QUAD_QUEUE_DEFERRED, 64'h3000, 64'h5000, QIE_EXC_NONE);
		`CHK("quad status", 64'h1, r0)
		op(QIE_REMOVE_LONG_HEAD_LOCKED, H + 4, 64'h0, ILL);
		op(QIE_REMOVE_LONG_HEAD_LOCKED, H | 64'h100000000, 64'h0, ILL);
		rem(32'h0, 32'h0, 0, '1, QIE_EXC_NONE, 32'h0);
		`CHK("empty", {rem_status(32'h0, 32'h0), H}, {r0, r1})
		rem(32'h100, 32'hffffff00, 0, '1, QIE_EXC_NONE, 32'h0);
		`CHK("last", {rem_status(32'h100, 32'h0), H + 64'h100}, {r0, r1})
		rem(32'h100, 32'h100, 1, '1, QIE_EXC_NONE, 32'h200);
		`CHK("more", rem_status(32'h100, 32'h200), r0)
		`CHK("succ back", 32'hfffffe00, MEM.m[H + 64'h204])
		rem(32'h100, 32'h100, 2, '1, QIE_EXC_NONE, 32'h100);
		`CHK("lock fail", 64'hffffffffffffffff, r0)
		rem(32'h103, 32'h100, 0, '1, ILL, 32'h103);
		rem(32'h100, 32'hffffff00, 0, H + 4, QIE_EXC_FAULT_ON_READ, 32'h100);
		rem(32'h100, 32'hffffff04, 0, '1, ILL, 32'h100);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
